/* inc/hspi_defines.vh */
`ifndef HSPI_DEFINES_VH
`define HSPI_DEFINES_VH

// ****************************************
// frame layout
// ****************************************
`define HSPI_FRAME_BITS      16
`define HSPI_CMD_BITS        8
`define HSPI_IDX_W           7
`define HSPI_DATA_W          8
`define HSPI_DIR_READ        1'b1
`define HSPI_DIR_WRITE       1'b0

// ****************************************
// register indices named by the host side
// ****************************************
`define HSPI_IDX_DUMMY       7'h7F
`define HSPI_IDX_NONVOL_CFG  7'h70
`define HSPI_IDX_IF_CONF     7'h6B
`define HSPI_SPI_LOCK_BIT    0
`define HSPI_THREE_WIRE_BIT  0

// ****************************************
// reset values
// ****************************************
`define HSPI_RST_THREE_WIRE  1'b0
`define HSPI_RST_SPI_MODE    1'b0

// ****************************************
// timing
// ****************************************
`define HSPI_CLK_PERIOD_PS   25000
`define HSPI_WR_IDLE_US      450
`define HSPI_WR_IDLE_CYC     ((`HSPI_WR_IDLE_US * 1000000 + `HSPI_CLK_PERIOD_PS - 1) / `HSPI_CLK_PERIOD_PS)

`endif

/* logic/hspi_sync2.v */
`timescale 1ns/100ps

// ****************************************
// two-stage synchroniser, one per bit
// ****************************************
module hspi_sync2 #(
    parameter W = 3,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // clock and reset
    input  wire         core_clk_i,
    input  wire         reset_n_i,
    // data
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    meta_q <= INIT[g];
                    sync_q <= INIT[g];
                end else begin
                    meta_q <= async_i[g];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[g] = sync_q;
        end
    endgenerate
endmodule // hspi_sync2

/* logic/hspi_slave.v */
`timescale 1ns/100ps
`include "hspi_defines.vh"

// Overview of operation
// - start in two-wire mode while select stays high
// - select rising edge latches SPI until reset
// - nonvolatile lock bit forces SPI permanently
// - clock mode from clock level at select fall
// - 4-wire default, three-wire bit selects 3-wire
// - 3-wire uses input pin bidirectionally, same frame
// - 16-bit frames, multi-byte within one select
// - master owns select and serial clock
// - drive on falling, sample on rising edge
// - output pin released during whole write
// - first bit direction, then 7-bit index
// - bits 8-15 carry write or read data
// - burst read auto-increments index per byte
module hspi_slave (
    // clock and reset
    input  wire       core_clk_i,
    input  wire       reset_n_i,
    // spi pins
    input  wire       chip_select_low_n_i,
    input  wire       shared_clock_pin_i,
    input  wire       serial_in_line_i,
    output wire       serial_in_line_o,
    output wire       serial_in_line_oe_n_o,
    output wire       serial_out_line_o,
    output wire       serial_out_line_oe_n_o,
    // configuration
    input  wire       spi_lock_i,
    input  wire       three_wire_select_i,
    // status
    output wire       spi_mode_o,
    output wire       clock_mode_11_o,
    output wire       busy_o,
    // register side
    output reg  [6:0] reg_idx_o,
    output reg        reg_rd_o,
    input  wire [7:0] reg_rdata_i,
    output reg        reg_wr_o,
    output reg  [7:0] reg_wdata_o
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    wire [2:0] pins_s;
    hspi_sync2 #(
        .W    (3),
        .INIT (3'b011)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .async_i    ({serial_in_line_i, shared_clock_pin_i, chip_select_low_n_i}),
        .sync_o     (pins_s)
    );
    wire cs_n_s = pins_s[0];
    wire sck_s  = pins_s[1];
    wire din_s  = pins_s[2];

    reg cs_n_q;
    reg sck_q;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cs_n_q <= 1'b1;
            sck_q  <= 1'b1;
        end else begin
            cs_n_q <= cs_n_s;
            sck_q  <= sck_s;
        end
    end
    wire cs_fall  = cs_n_q & ~cs_n_s;
    wire cs_rise  = ~cs_n_q & cs_n_s;
    wire active   = ~cs_n_s & ~cs_n_q;
    wire sck_rise = active & ~sck_q & sck_s;
    wire sck_fall = active & sck_q & ~sck_s;

    // ****************************************
    // protocol selection
    // ****************************************
    reg spi_seen_q;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spi_seen_q <= `HSPI_RST_SPI_MODE;
        end else if (cs_rise) begin
            spi_seen_q <= 1'b1;
        end
    end
    // lock bit bypasses the toggle requirement after every reset
    wire spi_mode = spi_seen_q | spi_lock_i;
    assign spi_mode_o = spi_mode;

    // ****************************************
    // clock mode and wire count
    // ****************************************
    reg mode11_q;
    reg three_w_q;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode11_q  <= 1'b0;
            three_w_q <= `HSPI_RST_THREE_WIRE;
        end else begin
            if (cs_fall) begin
                mode11_q <= sck_s;
            end
            // only change wire count between frames so a frame never
            // switches pins halfway
            if (cs_n_s) begin
                three_w_q <= three_wire_select_i;
            end
        end
    end
    assign clock_mode_11_o = mode11_q;

    // ****************************************
    // frame engine
    // ****************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_CMD  = 3'b010;
    localparam ST_DATA = 3'b100;

    reg [2:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg       dir_rd_q;
    reg [7:0] tx_q;
    reg       dout_q;
    reg       drive_q;
    reg       fetch_q;

    assign busy_o = ~state_q[0];

    // in mode 00 the first bit must be ready before any clock edge
    wire early_load = (state_q == ST_DATA) & dir_rd_q & (bit_cnt_q == 4'h0);

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q     <= ST_IDLE;
            bit_cnt_q   <= 4'h0;
            shift_q     <= 8'h00;
            dir_rd_q    <= 1'b0;
            tx_q        <= 8'h00;
            dout_q      <= 1'b0;
            drive_q     <= 1'b0;
            fetch_q     <= 1'b0;
            reg_idx_o   <= 7'h00;
            reg_rd_o    <= 1'b0;
            reg_wr_o    <= 1'b0;
            reg_wdata_o <= 8'h00;
        end else begin
            reg_rd_o <= 1'b0;
            reg_wr_o <= 1'b0;
            fetch_q  <= reg_rd_o;
            // write index moves on only after its strobe, so the strobe
            // always carries the index the data belongs to
            if (reg_wr_o) begin
                reg_idx_o <= reg_idx_o + 7'h01;
            end
            if (fetch_q) begin
                tx_q <= reg_rdata_i;
            end
            if (!spi_mode || cs_n_s) begin
                state_q   <= ST_IDLE;
                drive_q   <= 1'b0;
                bit_cnt_q <= 4'h0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (cs_fall) begin
                            state_q   <= ST_CMD;
                            bit_cnt_q <= 4'h0;
                            dir_rd_q  <= 1'b0;
                        end
                    end
                    ST_CMD: begin
                        if (sck_rise) begin
                            shift_q   <= {shift_q[6:0], din_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'h7) begin
                                // first bit is direction, then index
                                dir_rd_q  <= shift_q[6];
                                reg_idx_o <= {shift_q[5:0], din_s};
                                reg_rd_o  <= shift_q[6];
                                state_q   <= ST_DATA;
                                bit_cnt_q <= 4'h0;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (early_load && fetch_q) begin
                            dout_q  <= reg_rdata_i[7];
                            drive_q <= 1'b1;
                        end
                        if (sck_fall && dir_rd_q && bit_cnt_q != 4'h0) begin
                            dout_q <= tx_q[3'h7 - bit_cnt_q[2:0]];
                        end
                        if (sck_rise) begin
                            shift_q   <= {shift_q[6:0], din_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'h7) begin
                                bit_cnt_q <= 4'h0;
                                if (dir_rd_q) begin
                                    reg_idx_o <= reg_idx_o + 7'h01;
                                    reg_rd_o  <= 1'b1;
                                end else begin
                                    reg_wdata_o <= {shift_q[6:0], din_s};
                                    reg_wr_o    <= 1'b1;
                                end
                            end
                        end
                        if (sck_fall && bit_cnt_q == 4'h0 && !dir_rd_q) begin
                            drive_q <= 1'b0;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    // read data stays on the line through the last bit; the host
    // samples on its rising edge before select rises
    wire rd_drive = drive_q & dir_rd_q & (state_q == ST_DATA);
    assign serial_out_line_o      = dout_q;
    assign serial_out_line_oe_n_o = ~(rd_drive & ~three_w_q);
    assign serial_in_line_o       = dout_q;
    assign serial_in_line_oe_n_o  = ~(rd_drive & three_w_q);
endmodule // hspi_slave

/* test/hspi_master_model.sv */
`timescale 1ns/100ps
// ****
// spi master on the far side
// ****
module hspi_master_model (
    input  wire core_clk_i,
    output reg  cs_n,
    output reg  sck,
    output reg  mosi,
    output reg  mosi_oe,
    input  wire miso
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        mosi = 1'b0;
        mosi_oe = 1'b0;
    end
    // sampling late in the high phase gives the synchronised slave its full half bit
    task automatic xfer(input int n, input logic [31:0] tx, input logic cpol,
                        input logic rel, output logic [31:0] rx);
        rx = '0;
        sck = cpol;
        repeat (4) @(negedge core_clk_i);
        cs_n = 1'b0;
        repeat (4) @(negedge core_clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            sck = 1'b0;
            mosi = tx[i];
            mosi_oe = !(rel && i < n - 8);
            repeat (4) @(negedge core_clk_i);
            sck = 1'b1;
            repeat (4) @(negedge core_clk_i);
            rx[i] = miso;
        end
        sck = cpol;
        repeat (4) @(negedge core_clk_i);
        cs_n = 1'b1;
        mosi_oe = 1'b0;
        repeat (12) @(negedge core_clk_i);
    endtask
endmodule // hspi_master_model

/* test/hspi_slave_chk.sv */
`timescale 1ns/100ps
// ****
// port checker
// ****
module hspi_slave_chk (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire chip_select_low_n_i,
    input wire spi_lock_i,
    input wire three_wire_select_i,
    input wire serial_in_line_oe_n_o,
    input wire serial_out_line_oe_n_o,
    input wire spi_mode_o,
    input wire busy_o,
    input wire reg_rd_o,
    input wire reg_wr_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_two_wire_quiet: assert property (!spi_mode_o |-> serial_in_line_oe_n_o
        && serial_out_line_oe_n_o && !reg_rd_o && !reg_wr_o) else $error("two-wire activity");
    a_mode_sticky: assert property (spi_mode_o |=> spi_mode_o)
        else $error("spi mode lost");
    a_lock_forces: assert property (spi_lock_i |-> spi_mode_o)
        else $error("lock ignored");
    a_idle_release: assert property (chip_select_low_n_i [*6] |->
        serial_in_line_oe_n_o && serial_out_line_oe_n_o) else $error("drive while idle");
    a_one_driver: assert property (serial_in_line_oe_n_o || serial_out_line_oe_n_o)
        else $error("both lines driven");
    a_three_pin: assert property (!serial_in_line_oe_n_o |-> three_wire_select_i)
        else $error("shared line driven in 4-wire");
    a_four_pin: assert property (!serial_out_line_oe_n_o |-> !three_wire_select_i)
        else $error("output line driven in 3-wire");
    a_write_quiet: assert property (reg_wr_o |-> serial_out_line_oe_n_o
        && serial_in_line_oe_n_o) else $error("drive during write");
    a_rd_spacing: assert property (reg_rd_o |=> !reg_rd_o [*8])
        else $error("read strobes too close");
    a_wr_spacing: assert property (reg_wr_o |=> !reg_wr_o [*8])
        else $error("write strobes too close");
    a_strobe_framed: assert property (reg_rd_o || reg_wr_o |-> busy_o)
        else $error("strobe outside frame");
endmodule // hspi_slave_chk

bind hspi_slave hspi_slave_chk u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .chip_select_low_n_i(chip_select_low_n_i), .spi_lock_i(spi_lock_i),
    .three_wire_select_i(three_wire_select_i), .serial_in_line_oe_n_o(serial_in_line_oe_n_o),
    .serial_out_line_oe_n_o(serial_out_line_oe_n_o), .spi_mode_o(spi_mode_o),
    .busy_o(busy_o), .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o));

/* test/primary_host_spi_slave_port_tb.sv */
`timescale 1ns/100ps
`include "hspi_defines.vh"
// ****
// bench top
// ****
module primary_host_spi_slave_port_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        lock = 1'b0;
    logic        tw = 1'b0;
    logic        flip = 1'b0;
    logic [31:0] rx;
    logic [14:0] wq[$];
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    wire         cs_n, sck, mosi, mosi_oe, si_o, si_oe_n, so_o, so_oe_n;
    wire         mode, cm11, busy, rd, wr;
    wire [6:0]   idx;
    wire [7:0]   wdata;
    // released lines toggle so a stale level never passes
    wire         in_w = !si_oe_n ? si_o : (mosi_oe ? mosi : flip);
    wire         out_w = !so_oe_n ? so_o : flip;
    wire [7:0]   rdata = {1'b0, idx} ^ 8'hA5;

    hspi_master_model m (.core_clk_i(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi),
        .mosi_oe(mosi_oe), .miso(tw ? in_w : out_w));
    hspi_slave uut (.core_clk_i(clk), .reset_n_i(rst_n), .chip_select_low_n_i(cs_n),
        .shared_clock_pin_i(sck), .serial_in_line_i(in_w), .serial_in_line_o(si_o),
        .serial_in_line_oe_n_o(si_oe_n), .serial_out_line_o(so_o),
        .serial_out_line_oe_n_o(so_oe_n), .spi_lock_i(lock), .three_wire_select_i(tw),
        .spi_mode_o(mode), .clock_mode_11_o(cm11), .busy_o(busy), .reg_idx_o(idx),
        .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_wdata_o(wdata));

    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        flip <= ~flip;
        cyc <= cyc + 1;
        if (wr === 1'b1) wq.push_back({idx, wdata});
        if (cyc == 24000) begin
            miscompares++;
            report_and_stop;
        end
    end

    function logic [7:0] ex(input logic [6:0] a);
        ex = {1'b0, a} ^ 8'hA5;
    endfunction
    task chk(input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task wchk(input logic [14:0] e);
        chk(e, wq.size() ? wq.pop_front() : 'x);
    endtask
    task do_reset(input logic l);
        @(negedge clk);
        rst_n = 1'b0;
        lock = l;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task report_and_stop;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        do_reset(1'b0);
        chk(0, mode);
        m.xfer(16, {1'b0, 7'h12, 8'h3C}, 1'b1, 1'b0, rx);
        chk(0, wq.size());
        chk(1, mode);
        m.xfer(16, {1'b1, 7'h7F, 8'h00}, 1'b1, 1'b0, rx);
        chk(ex(7'h7F), rx[7:0]);
        chk(1, cm11);
        m.xfer(16, {1'b0, 7'h12, 8'h3C}, 1'b1, 1'b0, rx);
        wchk({7'h12, 8'h3C});
        m.xfer(32, {1'b1, 7'h02, 24'h0}, 1'b0, 1'b0, rx);
        chk(0, cm11);
        for (int k = 0; k < 3; k++) chk(ex(7'(2 + k)), rx[23 - 8 * k -: 8]);
        m.xfer(24, {1'b0, 7'h40, 16'h1122}, 1'b0, 1'b0, rx);
        wchk({7'h40, 8'h11});
        wchk({7'h41, 8'h22});
        tw = 1'b1;
        m.xfer(16, {1'b1, 7'h30, 8'h00}, 1'b1, 1'b1, rx);
        chk(ex(7'h30), rx[7:0]);
        m.xfer(16, {1'b0, 7'h31, 8'h5A}, 1'b1, 1'b0, rx);
        wchk({7'h31, 8'h5A});
        tw = 1'b0;
        do_reset(1'b1);
        chk(1, mode);
        m.xfer(16, {1'b0, 7'h55, 8'hC3}, 1'b0, 1'b0, rx);
        wchk({7'h55, 8'hC3});
        repeat (`HSPI_WR_IDLE_CYC) @(negedge clk);
        m.xfer(16, {1'b0, 7'h56, 8'h81}, 1'b0, 1'b0, rx);
        wchk({7'h56, 8'h81});
        report_and_stop;
    end
endmodule // primary_host_spi_slave_port_tb
